// ---- hdl/pin_sync.sv ----
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W         = 3,
  parameter logic [2:0] RESET_VAL = 3'h7
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_ff <= RESET_VAL[W-1:0];
      q       <= RESET_VAL[W-1:0];
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule // pin_sync

// ---- hdl/reg_mem.sv ----
// byte-wide register memory with registered read data
`timescale 1ns/1ps
module reg_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // contents survive reset on purpose, only the read register clears
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rd_data <= '0;
    else
      rd_data <= mem[rd_addr];
  end

endmodule // reg_mem

// ---- hdl/spi_sample_ready_port.sv ----
// serial register and sample port with combined data-ready signalling
`timescale 1ns/1ps

// What this block does
// R1: address advances after every data byte while slave select stays low.
// R2: host closes a transaction by raising slave select before another operation.
// R3: sample mode streams the 16-bit result without any read command.
// R4: sample bits leave msb first, changing on falling serial clock edges.
// R5: register reads are unreliable in sample or combined mode; host disables both.
// R6: combined enable low means the shared pin is plain data out.
// R7: combined enable never alters the separate ready output.
// R8: shared pin floats whenever slave select is high.
// R9: combined enable high puts data and active-low ready on the shared pin.
// R10: conversion done pulls pin low, or pulses high then low if already low.
// R11: host sees falling edge as new result, then gives 16 clocks.
// R12: after the full result, next rising clock edge drives pin high.
// R13: host may poll low level after a no-operation command.
// R14: after register read byte, next rising edge drives pin high too.
// R15: host uses combined mode only with a single slave.
// R16: host keeps slave select low throughout combined mode.
// R17: slave select driven low about 250 us after reset or soft reset.
// R18: host may watch the released slave select to detect start-up end.
// R19: direction bit, 7-bit address, then data, all msb first.
// R20: sample on rising edges, change on falling edges, clock idles low.
// R21: writing 0xde to the soft reset register resets the device.
// R22: result captured as one 16-bit unit before shifting starts.
module spi_sample_ready_port #(
  parameter int STARTUP_CYCLES = spi_ready_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // serial link pins
  input  wire logic                       sclk,
  input  wire logic                       mosi,
  input  wire logic                       ss_n_in,
  output logic                            ss_n_out,
  output logic                            ss_n_oe_n,
  output logic                            miso_out,
  output logic                            miso_oe_n,
  // converter side
  input  wire spi_ready_pkg::result_in_t  result_in,
  output logic                            ready_n,
  output logic [spi_ready_pkg::DATA_W-1:0] config_a,
  output logic [spi_ready_pkg::DATA_W-1:0] config_e
);
  import spi_ready_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  spi_in_t       pins_s;
  link_state_t   state_ff, nxt_state;
  logic [16:0]   startup_cnt_ff;
  logic          sclk_d_ff, ss_n_d_ff;
  logic [3:0]    bit_cnt_ff;
  logic [7:0]    rx_ff;
  logic [6:0]    addr_ff;
  logic          dir_ff;
  logic [15:0]   tx_ff, result_ff;
  logic          load_ff, active_ff, pulse_ff, soft_rst_ff;
  logic [4:0]    shift_cnt_ff, frame_len_ff;
  logic [7:0]    cfg_a_ff, cfg_e_ff, mem_rdata;
  logic          miso_ff, nxt_miso;

  wire           srst       = ~reset_n | soft_rst_ff;
  wire           rise       = pins_s.sclk & ~sclk_d_ff;
  wire           fall       = ~pins_s.sclk & sclk_d_ff;
  wire           ss_start   = ss_n_d_ff & ~pins_s.ss_n & (state_ff == ST_IDLE);
  wire           in_frame   = ((state_ff == ST_CMD) | (state_ff == ST_DATA)) & ~pins_s.ss_n;
  wire [7:0]     nxt_rx     = {rx_ff[6:0], pins_s.mosi};
  wire           byte_done  = rise & in_frame & (bit_cnt_ff[2:0] == BYTE_LAST_BIT);
  wire           cmd_done   = byte_done & (state_ff == ST_CMD);
  wire           data_done  = byte_done & (state_ff == ST_DATA);
  wire           wr_en      = data_done & ~dir_ff;
  wire           read_next  = cmd_done ? nxt_rx[DIR_BIT] : (data_done & dir_ff);
  wire           comb       = cfg_e_ff[COMBINED_EN_BIT];
  wire           stream     = cfg_a_ff[SAMPLE_EN_BIT] | comb;
  wire           conv_evt   = result_in.done;
  wire           comb_evt   = conv_evt & comb;
  wire           frame_go   = ss_start & stream & ~comb;
  wire           sample_done = rise & in_frame & stream & ~comb & (bit_cnt_ff == SAMPLE_LAST_BIT);
  wire           shift_now  = fall & in_frame & (~comb | active_ff);
  wire           comb_force = rise & comb & active_ff & (shift_cnt_ff == frame_len_ff);
  wire           soft_hit   = wr_en & (addr_ff == ADDR_SOFT_RESET) & (nxt_rx == SOFT_RESET_KEY);
  wire           start_done = (startup_cnt_ff == 17'(STARTUP_CYCLES - 1));

  // result bytes come from the live capture, other non-config bytes from memory
  // config reads come from the live registers, memory keeps stale bytes across soft reset
  wire [7:0]     rd_byte    = (addr_ff == ADDR_RESULT_LOW)  ? result_ff[7:0]  :
                              (addr_ff == ADDR_RESULT_HIGH) ? result_ff[15:8] :
                              (addr_ff == ADDR_CONFIG_A)    ? cfg_a_ff        :
                              (addr_ff == ADDR_CONFIG_E)    ? cfg_e_ff        : mem_rdata;
  wire [15:0]    nxt_tx     = load_ff ? (stream ? result_ff : {rd_byte, 8'h00})  // [R5]
                                      : {tx_ff[14:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  pin_sync #(
    .W         (3),
    .RESET_VAL (3'h1)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({sclk, mosi, ss_n_in}),
    .q       (pins_s)
  );

  reg_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (wr_en),
    .wr_addr (addr_ff),
    .wr_data (nxt_rx),
    .rd_addr (addr_ff),
    .rd_data (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link state and start-up hold
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_START: if (start_done) nxt_state = ST_IDLE;                  // [R17]
      ST_IDLE:  if (ss_start) nxt_state = ST_CMD;
      ST_CMD:   if (pins_s.ss_n) nxt_state = ST_IDLE;
                else if (cmd_done) nxt_state = ST_DATA;               // [R19]
      ST_DATA:  if (pins_s.ss_n) nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_ff <= ST_START;
    else
      state_ff <= nxt_state;
  end

  // counted in core cycles so the pin is held for the full least time
  always_ff @(posedge clk)
  begin
    if (srst)
      startup_cnt_ff <= '0;
    else if (state_ff == ST_START)
      startup_cnt_ff <= startup_cnt_ff + 17'h1;                      // [R17]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ss_n_out  <= 1'b0;
      ss_n_oe_n <= 1'b0;
    end
    else
    begin
      ss_n_out  <= 1'b0;
      ss_n_oe_n <= (nxt_state != ST_START);                          // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receive: sample on rising edges
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sclk_d_ff <= 1'b0;
      ss_n_d_ff <= 1'b1;
    end
    else
    begin
      sclk_d_ff <= pins_s.sclk;
      ss_n_d_ff <= pins_s.ss_n;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst | ss_start)
      bit_cnt_ff <= '0;
    else if (rise & in_frame)
      bit_cnt_ff <= bit_cnt_ff + 4'h1;                               // [R20]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rx_ff <= '0;
    else if (rise & in_frame)
      rx_ff <= nxt_rx;                                               // [R20] [R19]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dir_ff  <= 1'b0;
      addr_ff <= '0;
    end
    else if (cmd_done)
    begin
      dir_ff  <= nxt_rx[DIR_BIT];                                    // [R19]
      addr_ff <= nxt_rx[6:0];
    end
    else if (data_done)
      addr_ff <= addr_ff + 7'h1;                                     // [R1]
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers and soft reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_a_ff <= CONFIG_A_RESET;
      cfg_e_ff <= CONFIG_E_RESET;
    end
    else if (wr_en & (addr_ff == ADDR_CONFIG_A))
      cfg_a_ff <= nxt_rx;
    else if (wr_en & (addr_ff == ADDR_CONFIG_E))
      cfg_e_ff <= nxt_rx;
  end

  // one-cycle pulse; it clears itself through srst
  always_ff @(posedge clk)
  begin
    if (srst)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= soft_hit;                                       // [R21]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      config_a <= CONFIG_A_RESET;
      config_e <= CONFIG_E_RESET;
    end
    else
    begin
      config_a <= cfg_a_ff;
      config_e <= cfg_e_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result capture, whole word at once
  always_ff @(posedge clk)
  begin
    if (srst)
      result_ff <= RESULT_RESET;
    else if (conv_evt)
      result_ff <= result_in.code;                                   // [R22]
  end

  // separate ready: low on new result, high once it has been taken
  always_ff @(posedge clk)
  begin
    if (srst)
      ready_n <= 1'b1;
    else if (conv_evt)
      ready_n <= 1'b0;                                               // [R7]
    else if (sample_done | (comb_force & (frame_len_ff == SAMPLE_BITS)) |
             (data_done & dir_ff & (addr_ff == ADDR_RESULT_HIGH)))
      ready_n <= 1'b1;                                               // [R7]
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit: change on falling edges
  always_ff @(posedge clk)
  begin
    if (srst)
      tx_ff <= '0;
    else if (frame_go)
      tx_ff <= result_ff;                                            // [R3] [R22]
    else if (shift_now)
      tx_ff <= nxt_tx;                                               // [R4]
  end

  // a pending load makes the next falling edge present a fresh msb
  always_ff @(posedge clk)
  begin
    if (srst | ss_start)
      load_ff <= 1'b0;
    else if (read_next | sample_done | comb_evt)
      load_ff <= 1'b1;                                               // [R3]
    else if (shift_now)
      load_ff <= 1'b0;
  end

  // frame tracking for the forced-high edge in combined mode
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      active_ff    <= 1'b0;
      shift_cnt_ff <= '0;
      frame_len_ff <= SAMPLE_BITS;
    end
    else if (comb_evt)
    begin
      active_ff    <= 1'b1;
      shift_cnt_ff <= '0;
      frame_len_ff <= SAMPLE_BITS;                                   // [R12]
    end
    else if (read_next)
    begin
      active_ff    <= 1'b1;
      shift_cnt_ff <= '0;
      frame_len_ff <= BYTE_BITS;                                     // [R14]
    end
    else if (comb_force | ~comb)
      active_ff    <= 1'b0;
    else if (shift_now & active_ff)
      shift_cnt_ff <= shift_cnt_ff + 5'h1;
  end

  // the re-signal pulse lasts one core cycle, enough for a falling edge
  always_ff @(posedge clk)
  begin
    if (srst)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= comb_evt & ~miso_ff;                               // [R10]
  end

  always_comb
  begin
    nxt_miso = miso_ff;
    if (comb_evt)
      nxt_miso = ~miso_ff;                                           // [R10] [R9]
    else if (pulse_ff)
      nxt_miso = 1'b0;                                               // [R10]
    else if (comb_force)
      nxt_miso = 1'b1;                                               // [R12] [R14]
    else if (shift_now)
      nxt_miso = nxt_tx[15];                                         // [R4] [R9]
    else if (frame_go)
      nxt_miso = result_ff[15];                                      // [R6] [R3]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      miso_ff   <= 1'b1;
      miso_oe_n <= 1'b1;
    end
    else
    begin
      miso_ff   <= nxt_miso;
      miso_oe_n <= pins_s.ss_n | (state_ff == ST_START);             // [R8]
    end
  end

  assign miso_out = miso_ff;

endmodule // spi_sample_ready_port

// ---- pkg/spi_ready_pkg.sv ----
// shared constants, types and register offsets of the serial sample-ready port
package spi_ready_pkg;

  // register offsets
  localparam logic [6:0] ADDR_SOFT_RESET  = 7'h44;
  localparam logic [6:0] ADDR_RESULT_LOW  = 7'h50;
  localparam logic [6:0] ADDR_RESULT_HIGH = 7'h51;
  localparam logic [6:0] ADDR_CONFIG_A    = 7'h52;
  localparam logic [6:0] ADDR_CONFIG_E    = 7'h56;

  // widths
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int RESULT_W = 16;

  // field positions
  localparam int DIR_BIT         = 7;
  localparam int SAMPLE_EN_BIT   = 0;
  localparam int COMBINED_EN_BIT = 0;

  // values
  localparam logic [7:0]  SOFT_RESET_KEY  = 8'hde;
  localparam logic [7:0]  CONFIG_A_RESET  = 8'h28;
  localparam logic [7:0]  CONFIG_E_RESET  = 8'h00;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [2:0]  BYTE_LAST_BIT   = 3'h7;
  localparam logic [3:0]  SAMPLE_LAST_BIT = 4'hf;
  localparam logic [4:0]  BYTE_BITS       = 5'h08;
  localparam logic [4:0]  SAMPLE_BITS     = 5'h10;

  // timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int STARTUP_TIME_US = 250;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // pins as seen from the link
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ss_n;
  } spi_in_t;

  // conversion result handed over by the converter
  typedef struct packed {
    logic        done;
    logic [15:0] code;
  } result_in_t;

  typedef enum logic [3:0] {
    ST_START = 4'b0001,
    ST_IDLE  = 4'b0010,
    ST_CMD   = 4'b0100,
    ST_DATA  = 4'b1000
  } link_state_t;

endpackage

// ---- verification/spi_host_model.sv ----
// host-side serial master driving the port's link pins
`timescale 1ns/1ps
module spi_host_model (
  // core clock used for pacing
  input wire logic clk,
  // link pins
  output logic     sclk,
  output logic     mosi,
  output logic     ss_n,
  input wire logic miso
);
  // 16 core cycles a half period gives the 160 ns link clock
  localparam int HALF = 16;
  initial
  begin
    sclk = 1'b0; // idles low
    mosi = 1'b0;
    ss_n = 1'b1; // pulled-high input through start-up
  end
  task automatic sel(input logic v);
    repeat (HALF) @(negedge clk);
    ss_n = v; // one operation per selection outside combined mode, single slave
    repeat (HALF) @(negedge clk);
  endtask
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi = tx[i]; // msb first, changed while clock low
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      rx[i] = miso; // taken at the rising edge
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule // spi_host_model

// ---- verification/spi_sample_ready_port_bench.sv ----
// self-checking bench for the serial sample-ready port
`timescale 1ns/1ps
module spi_sample_ready_port_bench;
  import spi_ready_pkg::*;
  localparam int START = 20;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  result_in_t  res       = '0;
  logic        miso_last = 1'b0;
  int          highs     = 0;
  logic        sclk, mosi, host_ss, ss_pin, miso_pin;
  logic        ss_n_out, ss_n_oe_n, miso_out, miso_oe_n, ready_n;
  logic [7:0]  config_a, config_e;
  logic [31:0] rx;
  logic [15:0] q;
  int          errors     = 0;
  int          num_checks = 0;
  always #2.5 clk = ~clk;
  // device pulls select low in start-up, else the host drives it
  assign ss_pin = ss_n_oe_n ? host_ss : ss_n_out;
  // a released data line shows the inverse of the last driven bit
  assign miso_pin = miso_oe_n ? ~miso_last : miso_out;
  always @(posedge clk)
  begin
    if (!miso_oe_n)
      miso_last <= miso_out;
    // counted, so a one-cycle pulse is not missed
    if (miso_pin === 1'b1)
      highs <= highs + 1;
  end
  spi_sample_ready_port #(.STARTUP_CYCLES(START)) i_spi_sample_ready_port (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .mosi(mosi), .ss_n_in(ss_pin),
    .ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .result_in(res), .ready_n(ready_n), .config_a(config_a), .config_e(config_e));
  spi_host_model i_spi_host_model (.clk(clk), .sclk(sclk), .mosi(mosi), .ss_n(host_ss), .miso(miso_pin));
  ////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic rw(input logic dir, input logic [6:0] a, input logic [15:0] d, input int nb);
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.xfer(nb == 2 ? {dir, a, d} : {8'h00, dir, a, d[7:0]}, 8 + 8 * nb, rx);
    i_spi_host_model.sel(1'b1); // raised before the next operation
    q = rx[15:0];
  endtask
  task automatic pulse(input logic [15:0] c);
    @(negedge clk);
    res = {1'b1, c};
    @(negedge clk);
    res.done = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic startup_check();
    int n;
    n = 0;
    chk_bit(ss_pin, 1'b0, "select held low");
    while (!ss_n_oe_n && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    chk_bit(n >= START - 1 && n <= START + 2, 1'b1, "start-up length");
    chk_val({8'h00, config_a}, {8'h00, CONFIG_A_RESET}, "config a reset");
    chk_val({8'h00, config_e}, {8'h00, CONFIG_E_RESET}, "config e reset");
    repeat (8) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    startup_check();
    $display("test start-up done");
    // burst crosses a read-only place into a writable one
    rw(1'b0, ADDR_RESULT_HIGH, 16'hff40, 2);
    chk_val({8'h00, config_a}, 16'h0040, "burst write");
    rw(1'b1, ADDR_RESULT_HIGH, 16'h0000, 2);
    chk_val(q, {RESULT_RESET[15:8], 8'h40}, "burst read");
    pulse(16'ha5c3);
    chk_bit(ready_n, 1'b0, "ready on result");
    rw(1'b1, ADDR_RESULT_LOW, 16'h0000, 2); // both modes off for reads
    chk_val(q, 16'hc3a5, "result read");
    chk_bit(ready_n, 1'b1, "ready cleared by read");
    $display("test register burst done");
    rw(1'b0, ADDR_CONFIG_A, 16'h0041, 1);
    pulse(16'h9b17);
    i_spi_host_model.sel(1'b0);
    i_spi_host_model.xfer(32'h0, 16, rx);
    i_spi_host_model.sel(1'b1);
    chk_val(rx[15:0], 16'h9b17, "sample word");
    chk_bit(ready_n, 1'b1, "ready cleared by frame");
    rw(1'b0, ADDR_CONFIG_A, 16'h0040, 1);
    $display("test sample shift done");
    rw(1'b0, ADDR_CONFIG_E, 16'h0001, 1);
    chk_val({8'h00, config_e}, 16'h0001, "combined enable");
    i_spi_host_model.sel(1'b0);
    pulse(16'h6e81);
    chk_bit(miso_pin, 1'b0, "ready falls");
    // 16 data pulses and one more rise that forces the pin high
    i_spi_host_model.xfer(32'h0, 17, rx);
    chk_val(rx[15:0], 16'h6e81, "combined word");
    chk_bit(miso_pin, 1'b1, "forced high");
    pulse(16'h3c5a);
    chk_bit(miso_pin, 1'b0, "ready falls again");
    n = highs;
    pulse(16'hc7e2);
    chk_bit(highs != n, 1'b1, "low pin pulsed high");
    chk_bit(miso_pin, 1'b0, "low after pulse");
    i_spi_host_model.xfer(32'h0, 17, rx);
    chk_val(rx[15:0], 16'hc7e2, "latest word");
    i_spi_host_model.sel(1'b1);
    chk_bit(miso_oe_n, 1'b1, "floats deselected");
    rw(1'b0, ADDR_CONFIG_E, 16'h0000, 1);
    $display("test combined ready done");
    rw(1'b0, ADDR_SOFT_RESET, {8'h00, SOFT_RESET_KEY}, 1);
    chk_val({8'h00, config_a}, {8'h00, CONFIG_A_RESET}, "soft reset");
    repeat (40) @(negedge clk);
    chk_bit(ss_n_oe_n, 1'b1, "select released");
    rw(1'b1, ADDR_CONFIG_A, 16'h0000, 1);
    chk_val({8'h00, q[7:0]}, {8'h00, CONFIG_A_RESET}, "config read after restart");
    $display("test soft reset done");
    // mid-run hardware reset must bring back the start-up drive
    rw(1'b0, ADDR_CONFIG_A, 16'h0040, 1);
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    startup_check();
    $display("test mid-run reset done");
    end_of_test();
  end
  initial
  begin
    #200000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // spi_sample_ready_port_bench

bind spi_sample_ready_port spi_sample_ready_port_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_monitor (
  .clk(clk), .reset_n(reset_n), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n),
  .miso_out(miso_out), .miso_oe_n(miso_oe_n), .result_in(result_in), .ready_n(ready_n),
  .config_a(config_a), .config_e(config_e));

// ---- verification/spi_sample_ready_port_monitor.sv ----
// assertions watching the serial sample-ready port at its pins
`timescale 1ns/1ps
module spi_sample_ready_port_monitor #(
  parameter int STARTUP_CYCLES = 20
) (
  // clock and reset
  input wire logic                            clk,
  input wire logic                            reset_n,
  // link pins
  input wire logic                            ss_n_in,
  input wire logic                            ss_n_out,
  input wire logic                            ss_n_oe_n,
  input wire logic                            miso_out,
  input wire logic                            miso_oe_n,
  // converter side
  input wire spi_ready_pkg::result_in_t       result_in,
  input wire logic                            ready_n,
  input wire logic [spi_ready_pkg::DATA_W-1:0] config_a,
  input wire logic [spi_ready_pkg::DATA_W-1:0] config_e
);
  import spi_ready_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // length of the current start-up drive, cleared once released
  int low_cnt_ff;
  always_ff @(posedge clk)
  begin
    if (!reset_n || ss_n_oe_n)
      low_cnt_ff <= 0;
    else
      low_cnt_ff <= low_cnt_ff + 1;
  end
  ////////////////////////////////////////////////////////////
  property p_ss_float;
    ss_n_in [*5] |-> miso_oe_n;
  endproperty
  a_ss_float: assert property (p_ss_float)
    else $error("shared pin driven while deselected");
  property p_start_hold;
    $rose(reset_n) |-> !ss_n_oe_n && !ss_n_out && miso_oe_n && ready_n && config_a == CONFIG_A_RESET;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("wrong pin state after reset");
  // one cycle of slack below and two above: the internal soft reset adds a cycle
  property p_start_len;
    $rose(ss_n_oe_n) |-> low_cnt_ff >= STARTUP_CYCLES - 1 && low_cnt_ff <= STARTUP_CYCLES + 2;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start-up drive of wrong length");
  property p_done_ready;
    result_in.done |=> !ready_n;
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("separate ready missed a result");
  property p_comb_fall;
    (!ss_n_in [*4] ##0 (config_e[COMBINED_EN_BIT] && result_in.done)) |-> ##[1:4] (!miso_out && !miso_oe_n);
  endproperty
  a_comb_fall: assert property (p_comb_fall)
    else $error("shared pin did not signal ready");
  property p_comb_pulse;
    !ss_n_in && config_e[COMBINED_EN_BIT] && result_in.done && !miso_out |-> ##[1:3] miso_out ##[1:3] !miso_out;
  endproperty
  a_comb_pulse: assert property (p_comb_pulse)
    else $error("low shared pin was not pulsed");
  property p_plain_quiet;
    ss_n_in && !config_e[COMBINED_EN_BIT] && !config_a[SAMPLE_EN_BIT] && result_in.done |=> $stable(miso_out) [*4];
  endproperty
  a_plain_quiet: assert property (p_plain_quiet)
    else $error("plain data pin moved on a result");
  property p_soft_reset;
    $fell(ss_n_oe_n) |-> ##[0:2] (config_a == CONFIG_A_RESET && config_e == CONFIG_E_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("restart left configuration set");
  c_comb: cover property (config_e[COMBINED_EN_BIT] && result_in.done);
  c_sample: cover property (config_a[SAMPLE_EN_BIT] && !ss_n_in);
  c_soft: cover property ($fell(ss_n_oe_n));
endmodule // spi_sample_ready_port_monitor
